//--- design/rtcr_regs.sv
/*
  Control, status and trickle-charge register bank of a binary-counter
  clock, with its watchdog/alarm counter and 250 ms pulse logic.
  Assumes a byte-wide register port driven by the serial-bus engine,
  one-cycle tick pulses for seconds and 1/4096 s, prepared square waves,
  and supply status inputs from the power monitor.
*/
// Functional notes
// - Oscillator-disable stops oscillator only on backup supply
// - Control resets to zero except both rate-select bits set
// - Counter enable runs 24-bit counter; off, bytes are plain storage
// - Mode clear: count down per second, reload from seed at zero
// - Mode set: count every 1/4096 s, set alarm flag, halt at zero
// - Watchdog mode: counter byte access before zero reloads counter
// - Backup square-wave bit keeps output below trip, else floats
// - Watchdog zero: 250 ms low on reset or interrupt per steering
// - Rate bits pick 1 Hz, 4.096, 8.192 or 32.768 kHz
// - Alarm interrupt enable and routing both needed for interrupt
// - Clearing alarm interrupt enable never shortens the pulse
// - Oscillator-stop flag set on any stop, held until written zero
// - Zero sets alarm flag; periodic mode holds interrupt low
// - Alarm flag clears on zero write; one write leaves it
// - Watchdog interrupt pulse 250 ms, then device clears flag
// - Charger enabled only with unlock nibble 1010, off at reset
// - Diode field 01 none, 10 one, 00 and 11 disable
// - Resistor field 01, 10, 11 choose resistor; 00 disables
`timescale 1ns/10ps
`include "rtcr_params.svh"
module rtcr_regs #(
  parameter int unsigned PULSE_CYCLES = int'(64'(`RTCR_PULSE_MS)
    * 64'(`RTCR_CLK_HZ) / 64'(`RTCR_MS_PER_S))
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_inhibit,
  input wire logic on_backup,
  input wire logic below_trip,
  input wire logic osc_fault,
  input wire logic irq_route_bit,
  input wire logic tick_sec,
  input wire logic tick_fast,
  input wire logic [3:0] sq_src,
  output logic osc_run,
  output logic standby,
  output logic square_wave_out,
  output logic square_wave_oe,
  output logic int_o,
  output logic int_oe,
  output logic rst_o,
  output logic rst_oe,
  output logic charge_en,
  output logic diode_en,
  output logic [1:0] res_sel
);
  if (PULSE_CYCLES < 2)
  begin : g_chk
    $error("rtcr_regs: PULSE_CYCLES must be at least 2");
  end

  logic [7:0] ctrl_q;
  logic osf_q;
  logic af_q;
  logic [7:0] chg_q;
  logic [7:0] rdata_q;
  logic [7:0] cnt_rdata;
  logic sqw_q;
  logic chg_en_q, diode_q;
  logic [1:0] res_q;
  rtcr_pkg::rtcr_target_e tgt_q;

  logic acc_wr, acc_rd;
  logic sel_cnt, sel_ctrl, sel_stat, sel_chg;
  logic zero_evt;
  logic pulse_start, pulse_active, pulse_done;
  logic mode, alarm_irq_enable, steer;
  logic osc_stopped;
  logic [1:0] rate;
  logic [1:0] byte_sel;

  assign mode = ctrl_q[`RTCR_CTRL_MODE];
  assign alarm_irq_enable = ctrl_q[`RTCR_CTRL_AIE];
  assign steer = ctrl_q[`RTCR_CTRL_STEER];
  assign rate = {ctrl_q[`RTCR_CTRL_RSH], ctrl_q[`RTCR_CTRL_RSL]};

  // A reset-steered pulse locks out register access for its duration
  assign reg_inhibit = pulse_active && (tgt_q == rtcr_pkg::RTCR_TGT_RST);
  assign acc_wr = reg_wr && !reg_inhibit;
  assign acc_rd = reg_rd && !reg_wr && !reg_inhibit;

  assign sel_cnt = (reg_addr == `RTCR_ADDR_CNT0)
    || (reg_addr == `RTCR_ADDR_CNT1) || (reg_addr == `RTCR_ADDR_CNT2);
  assign sel_ctrl = (reg_addr == `RTCR_ADDR_CTRL);
  assign sel_stat = (reg_addr == `RTCR_ADDR_STAT);
  assign sel_chg = (reg_addr == `RTCR_ADDR_CHG);
  assign byte_sel = 2'(reg_addr - `RTCR_ADDR_CNT0);

  rtcr_wdcnt u_cnt (
    .clk(clk),
    .rstn(rstn),
    .wr_en(acc_wr && sel_cnt),
    .rd_en(acc_rd && sel_cnt),
    .byte_sel(byte_sel),
    .wdata(reg_wdata),
    .rdata(cnt_rdata),
    .enable(ctrl_q[`RTCR_CTRL_CEN]),
    .mode(mode),
    // A counter written during the pulse starts once the pulse ends
    .hold(pulse_active),
    .tick_sec(tick_sec),
    .tick_fast(tick_fast),
    .zero_evt(zero_evt)
  );

  // Reset steering pulses regardless of enable; interrupt needs both gates
  assign pulse_start = zero_evt && mode
    && (!steer || (alarm_irq_enable && irq_route_bit));

  rtcr_pulse #(
    .CYCLES(PULSE_CYCLES)
  ) u_pulse (
    .clk(clk),
    .rstn(rstn),
    .start(pulse_start),
    .active(pulse_active),
    .done(pulse_done)
  );

  // Steering is latched so a control write cannot move a running pulse
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      tgt_q <= rtcr_pkg::RTCR_TGT_RST;
    else if (pulse_start && !pulse_active)
      tgt_q <= steer ? rtcr_pkg::RTCR_TGT_INT : rtcr_pkg::RTCR_TGT_RST;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      ctrl_q <= `RTCR_CTRL_RESET;
    else if (acc_wr && sel_ctrl)
      ctrl_q <= reg_wdata;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      chg_q <= `RTCR_CHG_RESET;
    else if (acc_wr && sel_chg)
      chg_q <= reg_wdata;
  end

  // Oscillator runs whenever main supply is present
  assign osc_run = !(ctrl_q[`RTCR_CTRL_OSCD] && on_backup);
  assign standby = !osc_run;
  assign osc_stopped = !osc_run || osc_fault;

  // Reset value covers first power-up; set wins over a software clear
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      osf_q <= `RTCR_OSF_RESET;
    else if (osc_stopped)
      osf_q <= 1'b1;
    else if (acc_wr && sel_stat && !reg_wdata[`RTCR_STAT_OSF])
      osf_q <= 1'b0;
  end

  // Pulse end clears the flag; a software clear never ends the pulse
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      af_q <= 1'b0;
    else if (zero_evt)
      af_q <= 1'b1;
    else if (pulse_done)
      af_q <= 1'b0;
    else if (acc_wr && sel_stat && !reg_wdata[`RTCR_STAT_AF])
      af_q <= 1'b0;
  end

  // Level interrupt in periodic mode, fixed pulse in watchdog mode
  assign int_oe = (pulse_active && (tgt_q == rtcr_pkg::RTCR_TGT_INT))
    || (!mode && af_q && alarm_irq_enable && irq_route_bit);
  assign int_o = 1'b0;
  assign rst_oe = pulse_active
    && (tgt_q == rtcr_pkg::RTCR_TGT_RST);
  assign rst_o = 1'b0;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      sqw_q <= 1'b0;
    else
      sqw_q <= sq_src[rate];
  end
  assign square_wave_out = sqw_q;
  assign square_wave_oe = !below_trip
    || ctrl_q[`RTCR_CTRL_BACKUP_SQUARE_WAVE_ENABLE];

  // Charger output only for the unlock nibble and legal selections
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      chg_en_q <= 1'b0;
      diode_q <= 1'b0;
      res_q <= `RTCR_RS_OFF;
    end
    else
    begin
      chg_en_q <= (chg_q[`RTCR_CHG_UNL_HI:`RTCR_CHG_UNL_LO]
        == `RTCR_CHG_UNLOCK)
        && ((chg_q[`RTCR_CHG_DS_HI:`RTCR_CHG_DS_LO] == `RTCR_DS_NONE)
        || (chg_q[`RTCR_CHG_DS_HI:`RTCR_CHG_DS_LO] == `RTCR_DS_ONE))
        && (chg_q[`RTCR_CHG_RS_HI:`RTCR_CHG_RS_LO]
        != `RTCR_RS_OFF);
      diode_q <= (chg_q[`RTCR_CHG_DS_HI:`RTCR_CHG_DS_LO]
        == `RTCR_DS_ONE);
      res_q <= chg_q[`RTCR_CHG_RS_HI:`RTCR_CHG_RS_LO];
    end
  end
  assign charge_en = chg_en_q;
  assign diode_en = chg_en_q && diode_q;
  // The smallest resistor is software's to avoid at high supply
  assign res_sel = chg_en_q ? res_q : `RTCR_RS_OFF;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      rdata_q <= `RTCR_READ_NONE;
    else if (acc_rd)
    begin
      if (sel_cnt)
        rdata_q <= cnt_rdata;
      else if (sel_ctrl)
        rdata_q <= ctrl_q;
      else if (sel_stat)
      begin
        rdata_q <= `RTCR_READ_NONE;
        rdata_q[`RTCR_STAT_OSF] <= osf_q;
        rdata_q[`RTCR_STAT_AF] <= af_q;
      end
      else if (sel_chg)
        rdata_q <= chg_q;
      else
        rdata_q <= `RTCR_READ_NONE;
    end
  end
  assign reg_rdata = rdata_q;

  sequence s_stat_read;
    acc_rd && sel_stat;
  endsequence

  sequence s_af_zero_write;
    acc_wr && sel_stat && !reg_wdata[`RTCR_STAT_AF];
  endsequence

  a_osc_main: assert property (@(posedge clk) disable iff (!rstn)
    !on_backup |-> osc_run && !standby)
    else $error("oscillator stopped on main supply");
  a_osf_sticky: assert property (@(posedge clk) disable iff (!rstn)
    osc_stopped |=> osf_q ##1 (osf_q || $past(acc_wr && sel_stat)))
    else $error("stop flag not set");
  a_af_set_wins: assert property (@(posedge clk) disable iff (!rstn)
    zero_evt and s_af_zero_write |=> af_q)
    else $error("alarm event lost to clear");
  a_af_one_keep: assert property (@(posedge clk) disable iff (!rstn)
    acc_wr && sel_stat && reg_wdata[`RTCR_STAT_AF] && !zero_evt
    && !pulse_done |=> af_q == $past(af_q))
    else $error("alarm flag changed by one write");
  a_stat_zeros: assert property (@(posedge clk) disable iff (!rstn)
    s_stat_read |=> reg_rdata[6:1] == 6'h00)
    else $error("status reserved bits not zero");
  a_int_level: assert property (@(posedge clk) disable iff (!rstn)
    !mode && af_q && alarm_irq_enable && irq_route_bit |-> int_oe)
    else $error("periodic alarm interrupt missing");
  a_int_gate: assert property (@(posedge clk) disable iff (!rstn)
    !pulse_active && (!alarm_irq_enable || !irq_route_bit) |-> !int_oe)
    else $error("interrupt without enable");
  a_pulse_hold: assert property (@(posedge clk) disable iff (!rstn)
    pulse_active && !pulse_done |=> pulse_active
    && $stable(tgt_q))
    else $error("pulse cut short");
  a_af_self_clr: assert property (@(posedge clk) disable iff (!rstn)
    pulse_done && !zero_evt |=> !af_q)
    else $error("alarm flag not cleared after pulse");
  a_chg_lock: assert property (@(posedge clk) disable iff (!rstn)
    chg_q[`RTCR_CHG_UNL_HI:`RTCR_CHG_UNL_LO] != `RTCR_CHG_UNLOCK
    |=> !charge_en)
    else $error("charger on without unlock");
  a_sqw_float: assert property (@(posedge clk) disable iff (!rstn)
    below_trip && !ctrl_q[`RTCR_CTRL_BACKUP_SQUARE_WAVE_ENABLE] |-> !square_wave_oe)
    else $error("square wave driven below trip");

  sequence s_wd_zero;
    zero_evt && mode;
  endsequence

  a_rst_steer: assert property (@(posedge clk) disable iff (!rstn)
    s_wd_zero ##0 !steer |=> rst_oe && reg_inhibit)
    else $error("reset pulse did not start");
  a_int_steer: assert property (@(posedge clk) disable iff (!rstn)
    s_wd_zero ##0 (steer && alarm_irq_enable && irq_route_bit)
    |=> int_oe && !rst_oe)
    else $error("interrupt pulse did not start");
  a_no_pulse: assert property (@(posedge clk) disable iff (!rstn)
    s_wd_zero ##0 (steer && !alarm_irq_enable) |=> !pulse_active && af_q)
    else $error("pulse without alarm enable");
  a_af_set: assert property (@(posedge clk) disable iff (!rstn)
    zero_evt |=> af_q)
    else $error("alarm flag not set at zero");
  a_af_clear: assert property (@(posedge clk) disable iff (!rstn)
    s_af_zero_write ##0 !zero_evt |=> !af_q)
    else $error("alarm flag not cleared by zero write");
  a_osf_clear: assert property (@(posedge clk) disable iff (!rstn)
    acc_wr && sel_stat && !reg_wdata[`RTCR_STAT_OSF] && !osc_stopped
    |=> !osf_q)
    else $error("stop flag not cleared by zero write");
  a_osc_backup: assert property (@(posedge clk) disable iff (!rstn)
    on_backup && ctrl_q[`RTCR_CTRL_OSCD]
    |-> !osc_run && standby)
    else $error("oscillator not stopped on backup");
  a_sqw_rate: assert property (@(posedge clk) disable iff (!rstn)
    1'b1 |=> square_wave_out == $past(sq_src[rate]))
    else $error("square wave rate wrong");
  a_sqw_main: assert property (@(posedge clk) disable iff (!rstn)
    !below_trip |-> square_wave_oe)
    else $error("square wave not driven on main supply");
  a_chg_diode: assert property (@(posedge clk) disable iff (!rstn)
    (chg_q[`RTCR_CHG_DS_HI:`RTCR_CHG_DS_LO] != `RTCR_DS_NONE)
    && (chg_q[`RTCR_CHG_DS_HI:`RTCR_CHG_DS_LO] != `RTCR_DS_ONE)
    |=> !charge_en)
    else $error("charger on with illegal diode field");
  a_chg_res: assert property (@(posedge clk) disable iff (!rstn)
    chg_q[`RTCR_CHG_RS_HI:`RTCR_CHG_RS_LO] == `RTCR_RS_OFF
    |=> !charge_en && res_sel == `RTCR_RS_OFF)
    else $error("charger on with no resistor");
  a_diode_pick: assert property (@(posedge clk) disable iff (!rstn)
    chg_q[`RTCR_CHG_UNL_HI:`RTCR_CHG_UNL_LO] == `RTCR_CHG_UNLOCK
    && chg_q[`RTCR_CHG_DS_HI:`RTCR_CHG_DS_LO] == `RTCR_DS_ONE
    && chg_q[`RTCR_CHG_RS_HI:`RTCR_CHG_RS_LO] != `RTCR_RS_OFF
    |=> charge_en && diode_en)
    else $error("diode not inserted");
endmodule

//--- common/rtcr_params.svh
/*
  Named constants of the clock control/status register bank: register
  addresses, field positions, reset values and timing figures.
  Assumes it is included by its bare name by the register bank and the bench.
*/
`ifndef RTCR_PARAMS_SVH
`define RTCR_PARAMS_SVH

`define RTCR_ADDR_CNT0 8'h04
`define RTCR_ADDR_CNT1 8'h05
`define RTCR_ADDR_CNT2 8'h06
`define RTCR_ADDR_CTRL 8'h07
`define RTCR_ADDR_STAT 8'h08
`define RTCR_ADDR_CHG 8'h10

`define RTCR_CTRL_RESET 8'h06
`define RTCR_STAT_RESET 8'h80
`define RTCR_OSF_RESET 1'b1
`define RTCR_CHG_RESET 8'h00
`define RTCR_READ_NONE 8'h00

`define RTCR_CTRL_OSCD 7
`define RTCR_CTRL_CEN 6
`define RTCR_CTRL_MODE 5
`define RTCR_CTRL_BACKUP_SQUARE_WAVE_ENABLE 4
`define RTCR_CTRL_STEER 3
`define RTCR_CTRL_RSH 2
`define RTCR_CTRL_RSL 1
`define RTCR_CTRL_AIE 0

`define RTCR_STAT_OSF 7
`define RTCR_STAT_AF 0

`define RTCR_CHG_UNL_HI 7
`define RTCR_CHG_UNL_LO 4
`define RTCR_CHG_DS_HI 3
`define RTCR_CHG_DS_LO 2
`define RTCR_CHG_RS_HI 1
`define RTCR_CHG_RS_LO 0
`define RTCR_CHG_UNLOCK 4'ha
`define RTCR_DS_NONE 2'h1
`define RTCR_DS_ONE 2'h2
`define RTCR_RS_OFF 2'h0

`define RTCR_PULSE_MS 250
`define RTCR_CLK_HZ 20000000
`define RTCR_MS_PER_S 1000

`endif

//--- common/rtcr_pkg.sv
/*
  Types shared by the register bank and its helper modules.
  Assumes nothing of its surroundings.
*/
package rtcr_pkg;
  typedef enum logic {RTCR_TGT_RST, RTCR_TGT_INT} rtcr_target_e;
  typedef enum {RTCR_P_IDLE, RTCR_P_ACTIVE} rtcr_pstate_e;
  typedef logic [23:0] rtcr_count_t;
endpackage

//--- design/rtcr_pulse.sv
/*
  Fixed-length low-pulse timer used for the watchdog pulse.
  Assumes start is a one-cycle request; starts while busy are ignored.
*/
`timescale 1ns/10ps
module rtcr_pulse #(
  parameter int unsigned CYCLES = 5000000
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic start,
  output logic active,
  output logic done
);
  localparam int W = $clog2(CYCLES + 1);

  if (CYCLES < 2)
  begin : g_chk
    $error("rtcr_pulse: CYCLES must be at least 2");
  end

  rtcr_pkg::rtcr_pstate_e state_q;
  logic [W-1:0] cnt_q;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_q <= rtcr_pkg::RTCR_P_IDLE;
      cnt_q <= '0;
    end
    else
    begin
      unique case (state_q)
        rtcr_pkg::RTCR_P_IDLE:
        begin
          if (start)
          begin
            state_q <= rtcr_pkg::RTCR_P_ACTIVE;
            cnt_q <= W'(CYCLES - 1);
          end
        end
        rtcr_pkg::RTCR_P_ACTIVE:
        begin
          if (cnt_q == '0)
            state_q <= rtcr_pkg::RTCR_P_IDLE;
          else
            cnt_q <= cnt_q - W'(1);
        end
      endcase
    end
  end

  assign active = (state_q == rtcr_pkg::RTCR_P_ACTIVE);
  assign done = active && (cnt_q == '0);

  // Helper: length of the current pulse
  logic [31:0] len_q;
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      len_q <= 32'h0000_0000;
    else if (active)
      len_q <= len_q + 32'h0000_0001;
    else
      len_q <= 32'h0000_0000;
  end

  a_pulse_len: assert property (@(posedge clk) disable iff (!rstn)
    $fell(active) |-> len_q == CYCLES)
    else $error("watchdog pulse length wrong");
  a_pulse_start: assert property (@(posedge clk) disable iff (!rstn)
    start && !active |=> active && !done)
    else $error("pulse did not start");
endmodule

//--- design/rtcr_wdcnt.sv
/*
  24-bit watchdog/alarm down counter with its seed and byte access.
  Assumes tick_sec and tick_fast are one-cycle pulses in the clk domain.
*/
`timescale 1ns/10ps
module rtcr_wdcnt (
  input wire logic clk,
  input wire logic rstn,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [1:0] byte_sel,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata,
  input wire logic enable,
  input wire logic mode,
  input wire logic hold,
  input wire logic tick_sec,
  input wire logic tick_fast,
  output logic zero_evt
);
  rtcr_pkg::rtcr_count_t seed_q, seed_d, count_q;
  logic halted_q;
  logic run;
  logic tick;

  always_comb
  begin
    seed_d = seed_q;
    seed_d[byte_sel*8 +: 8] = wdata;
  end

  assign tick = mode ? tick_fast : tick_sec;
  // All-zero seed disables the counter whatever the enable bit says
  assign run = enable && (seed_q != '0) && !halted_q && !hold;
  assign zero_evt = run && tick && (count_q <= 24'h00_0001) && !wr_en
    && !(rd_en && mode);
  assign rdata = count_q[byte_sel*8 +: 8];

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      seed_q <= '0;
    else if (wr_en)
      seed_q <= seed_d;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      count_q <= '0;
      halted_q <= 1'b0;
    end
    else if (wr_en)
    begin
      count_q <= seed_d;
      halted_q <= 1'b0;
    end
    else if (rd_en && mode && enable && !halted_q)
      count_q <= seed_q;
    else if (zero_evt)
    begin
      if (mode)
      begin
        count_q <= '0;
        halted_q <= 1'b1;
      end
      else
        count_q <= seed_q;
    end
    else if (run && tick)
      count_q <= count_q - 24'h00_0001;
  end

  a_wd_reload: assert property (@(posedge clk) disable iff (!rstn)
    rd_en && !wr_en && mode && enable && !halted_q
    |=> count_q == $past(seed_q))
    else $error("watchdog access did not reload");
  a_alarm_reload: assert property (@(posedge clk) disable iff (!rstn)
    zero_evt && !mode |=> count_q == $past(seed_q) && !halted_q)
    else $error("periodic alarm did not reload");
  a_wd_halt: assert property (@(posedge clk) disable iff (!rstn)
    zero_evt && mode |=> count_q == '0 && halted_q
    ##1 ((count_q == '0 && halted_q) || $past(wr_en)))
    else $error("watchdog did not halt at zero");
  a_cnt_idle: assert property (@(posedge clk) disable iff (!rstn)
    !enable && !wr_en |=> $stable(count_q))
    else $error("disabled counter changed");
endmodule

//--- sim/rtcr_timebase.sv
/*
  Timebase model for the register bank: one-cycle second and fast
  ticks and four prepared square waves, each faster than the last.
  Assumes one clock domain; periods are shrunk so runs stay short.
*/
`timescale 1ns/10ps
module rtcr_timebase (
  input wire logic clk,
  input wire logic rstn,
  output logic tick_sec,
  output logic tick_fast,
  output logic [3:0] sq_src
);
  logic [5:0] div_q;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      div_q <= 6'h00;
    end
    else
    begin
      div_q <= div_q + 6'h01;
    end
  end

  // Seconds every 64 cycles, fast ticks every 4, a ratio of 16 to keep runs short
  assign tick_sec = (div_q == 6'h3f);
  assign tick_fast = (div_q[1:0] == 2'h3);
  assign sq_src = {div_q[0], div_q[1], div_q[2], div_q[5]};
endmodule

//--- sim/test_rtcr_regs.sv
/*
  Self-checking bench of the register bank: register port tasks and
  scenarios for control, status, counter, pulses and charger.
  Assumes the bank, its header and the timebase model compile first.
*/
`timescale 1ns/10ps
`include "rtcr_params.svh"
module test_rtcr_regs;
  localparam int unsigned PC = 20;
  logic clk, rstn, reg_wr, reg_rd, reg_inhibit;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rd_v;
  logic on_backup, below_trip, osc_fault, irq_route_bit;
  logic tick_sec, tick_fast, osc_run, standby;
  logic square_wave_out, square_wave_oe;
  logic int_o, int_oe, rst_o, rst_oe, charge_en, diode_en;
  logic [3:0] sq_src, sq_prev;
  logic [1:0] res_sel;
  int fails, checks, n;
  logic [7:0] cv [8] = '{8'ha5, 8'haa, 8'hab, 8'ha6,
                         8'ha0, 8'haf, 8'ha4, 8'h55};
  logic [2:0] ce [8] = '{3'h5, 3'h6, 3'h7, 3'h6, 3'h0, 3'h0, 3'h0, 3'h0};
  logic dd [8] = '{1'h0, 1'h1, 1'h1, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0};

  rtcr_timebase tb_u (.clk(clk), .rstn(rstn), .tick_sec(tick_sec),
    .tick_fast(tick_fast), .sq_src(sq_src));

  rtcr_regs #(.PULSE_CYCLES(PC)) dut_u (.clk(clk), .rstn(rstn),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_inhibit(reg_inhibit), .on_backup(on_backup),
    .below_trip(below_trip), .osc_fault(osc_fault),
    .irq_route_bit(irq_route_bit), .tick_sec(tick_sec),
    .tick_fast(tick_fast), .sq_src(sq_src), .osc_run(osc_run),
    .standby(standby), .square_wave_out(square_wave_out),
    .square_wave_oe(square_wave_oe), .int_o(int_o), .int_oe(int_oe),
    .rst_o(rst_o), .rst_oe(rst_oe), .charge_en(charge_en),
    .diode_en(diode_en), .res_sel(res_sel));

  initial
  begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end

  // What the bank sampled at the last edge, for the one-cycle-late output
  always @(posedge clk) sq_prev <= sq_src;

  task automatic tally_and_finish();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
    begin
      $display("*** PASS ***");
    end
    else
    begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      fails++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check1(input logic got, input logic exp);
    check8({7'h00, got}, {7'h00, exp});
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'h1;
    @(negedge clk);
    reg_wr = 1'h0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1'h1;
    @(negedge clk);
    reg_rd = 1'h0;
    rd_v = reg_rdata;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    rd(a);
    check8(rd_v, exp);
  endtask

  task automatic set_seed(input logic [23:0] v);
    wr(`RTCR_ADDR_CNT0, v[7:0]);
    wr(`RTCR_ADDR_CNT1, v[15:8]);
    wr(`RTCR_ADDR_CNT2, v[23:16]);
  endtask

  function automatic logic sig(input int w);
    return (w == 0) ? int_oe : rst_oe;
  endfunction

  // Bounded wait, so a pulse that never comes fails instead of hanging
  task automatic wait_hi(input int w);
    int k;
    k = 0;
    while (sig(w) !== 1'h1 && k < 3000)
    begin
      @(negedge clk);
      k++;
    end
    check1(sig(w), 1'h1);
  endtask

  task automatic pulse_len(input int w);
    n = 0;
    while (sig(w) === 1'h1 && n < 1000)
    begin
      n++;
      @(negedge clk);
    end
  endtask

  // Span of 20000 cycles is over ten times the expected run
  initial
  begin
    #(50 * 20000);
    fails++;
    tally_and_finish();
  end

  initial
  begin
    {reg_wr, reg_rd, on_backup, below_trip, osc_fault} = 5'h00;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    irq_route_bit = 1'h1;
    fails = 0;
    checks = 0;
    rstn = 1'h0;
    repeat (16) @(negedge clk);
    rstn = 1'h1;
    rdchk(`RTCR_ADDR_CTRL, 8'h06);
    rdchk(`RTCR_ADDR_STAT, 8'h80);
    rdchk(`RTCR_ADDR_CHG, 8'h00);
    check1(charge_en, 1'h0);
    wr(8'h09, 8'hff);
    rdchk(8'h09, 8'h00);
    set_seed(24'h3c_5aa5);
    rdchk(`RTCR_ADDR_CNT0, 8'ha5);
    rdchk(`RTCR_ADDR_CNT1, 8'h5a);
    rdchk(`RTCR_ADDR_CNT2, 8'h3c);
    wr(`RTCR_ADDR_CTRL, 8'h86);
    check1(osc_run, 1'h1);
    on_backup = 1'h1;
    @(negedge clk);
    check1(osc_run, 1'h0);
    check1(standby, 1'h1);
    wr(`RTCR_ADDR_STAT, 8'h00);
    rdchk(`RTCR_ADDR_STAT, 8'h80);
    on_backup = 1'h0;
    wr(`RTCR_ADDR_CTRL, 8'h06);
    wr(`RTCR_ADDR_STAT, 8'h7e);
    rdchk(`RTCR_ADDR_STAT, 8'h00);
    osc_fault = 1'h1;
    @(negedge clk);
    osc_fault = 1'h0;
    rdchk(`RTCR_ADDR_STAT, 8'h80);
    wr(`RTCR_ADDR_STAT, 8'h00);
    for (int i = 0; i < 4; i++)
    begin
      wr(`RTCR_ADDR_CTRL, 8'(i << 1));
      repeat (70)
      begin
        @(negedge clk);
        check1(square_wave_out, sq_prev[i]);
      end
    end
    below_trip = 1'h1;
    on_backup = 1'h1;
    wr(`RTCR_ADDR_CTRL, 8'h16);
    check1(square_wave_oe, 1'h1);
    wr(`RTCR_ADDR_CTRL, 8'h06);
    check1(square_wave_oe, 1'h0);
    below_trip = 1'h0;
    on_backup = 1'h0;
    set_seed(24'h00_0003);
    wr(`RTCR_ADDR_CTRL, 8'h41);
    wait_hi(0);
    repeat (10) @(negedge clk);
    check1(int_oe, 1'h1);
    rdchk(`RTCR_ADDR_STAT, 8'h01);
    wr(`RTCR_ADDR_STAT, 8'h01);
    rdchk(`RTCR_ADDR_STAT, 8'h01);
    irq_route_bit = 1'h0;
    @(negedge clk);
    check1(int_oe, 1'h0);
    irq_route_bit = 1'h1;
    wr(`RTCR_ADDR_CTRL, 8'h40);
    check1(int_oe, 1'h0);
    wr(`RTCR_ADDR_STAT, 8'h00);
    rdchk(`RTCR_ADDR_STAT, 8'h00);
    wr(`RTCR_ADDR_CTRL, 8'h41);
    wait_hi(0);
    // Counter held off while the seed is loaded in fast mode
    wr(`RTCR_ADDR_CTRL, 8'h29);
    wr(`RTCR_ADDR_STAT, 8'h00);
    set_seed(24'h00_0008);
    wr(`RTCR_ADDR_CTRL, 8'h69);
    wait_hi(0);
    check1(int_o, 1'h0);
    check1(rst_oe, 1'h0);
    fork
      pulse_len(0);
      begin
        wr(`RTCR_ADDR_CTRL, 8'h68);
        rdchk(`RTCR_ADDR_STAT, 8'h01);
        wr(`RTCR_ADDR_STAT, 8'h00);
      end
    join
    check8(8'(n), 8'(PC));
    rdchk(`RTCR_ADDR_STAT, 8'h00);
    repeat (200) @(negedge clk);
    rdchk(`RTCR_ADDR_STAT, 8'h00);
    set_seed(24'h00_0028);
    repeat (8)
    begin
      repeat (30) @(negedge clk);
      rd(`RTCR_ADDR_CNT0);
    end
    rdchk(`RTCR_ADDR_STAT, 8'h00);
    repeat (300) @(negedge clk);
    rdchk(`RTCR_ADDR_STAT, 8'h01);
    check1(int_oe, 1'h0);
    rdchk(`RTCR_ADDR_CNT0, 8'h00);
    wr(`RTCR_ADDR_STAT, 8'h00);
    wr(`RTCR_ADDR_CTRL, 8'h60);
    set_seed(24'h00_0002);
    wait_hi(1);
    check1(reg_inhibit, 1'h1);
    check1(int_oe, 1'h0);
    check1(rst_o, 1'h0);
    pulse_len(1);
    check8(8'(n), 8'(PC));
    rdchk(`RTCR_ADDR_STAT, 8'h00);
    // Main supply taken as low, so the smallest resistor may be set
    for (int i = 0; i < 8; i++)
    begin
      wr(`RTCR_ADDR_CHG, cv[i]);
      @(negedge clk);
      check8({5'h00, charge_en, res_sel}, {5'h00, ce[i]});
      if (ce[i][2])
      begin
        check1(diode_en, dd[i]);
      end
      else
      begin
        check1(diode_en, 1'h0);
      end
    end
    rdchk(`RTCR_ADDR_CHG, 8'h55);
    tally_and_finish();
  end
endmodule
